// ===== seq_pkg.sv
// Package: register map, field layout, reset values and helpers of the table sequencer
package seq_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ENTROPY_SEQ_ADDR = 16'ha000;
	localparam logic [15:0] PRED_HIGH_ADDR = 16'ha004;
	localparam logic [15:0] PRED_LOW_ADDR = 16'ha008;
	localparam logic [15:0] CTRL_ADDR = 16'ha010;
	localparam logic [15:0] STATUS_ADDR = 16'ha014;
	localparam logic [15:0] DEC_LEN_ADDR = 16'ha80c;
	localparam logic [15:0] YC_SEQ_ADDR = 16'hbe08;
	localparam logic [15:0] AB_SEQ_ADDR = 16'hbe0c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int YC_LEN_MSB = 13;
	localparam int YC_LEN_LSB = 10;
	localparam int SEQ_MSB = 9;
	localparam int LEN_MSB = 3;
	localparam int CTRL_MODE_MSB = 2;
	localparam int CTRL_DECOMP_BIT = 3;
	localparam int STAT_QPOS_LSB = 0;
	localparam int STAT_EPOS_LSB = 4;
	localparam int STAT_FULL_LSB = 8;
	localparam int STAT_BYPASS_BIT = 12;

	// ----------------------------------------------------------------
	// Reset values, lengths, start bits, block timing
	// ----------------------------------------------------------------
	localparam logic [9:0] SEQ_RST = 10'h000;
	localparam logic [3:0] LEN_RST = 4'h8;
	localparam logic [3:0] SEQ_LEN_MIN = 4'h5;
	localparam logic [3:0] SEQ_LEN_MAX = 4'ha;
	localparam logic [3:0] START_GRAY_COMP = 4'h2;
	localparam logic [3:0] START_COLOR_COMP = 4'h5;
	localparam logic [3:0] START_DECOMP = 4'h2;
	localparam logic [3:0] START_ENTROPY = 4'h0;
	localparam int BLOCK_CYCLES = 64;
	localparam logic [5:0] BLOCK_LAST = 6'(BLOCK_CYCLES - 1);
	localparam int QUEUE_COUNT = 4;

	typedef enum logic [2:0] {
		MODE_GRAY,
		MODE_422,
		MODE_444,
		MODE_4444,
		MODE_RGB_TO_422,
		MODE_444_TO_422
	} pixel_mode_t;

	// Out-of-range lengths are forced into the legal window
	function automatic logic [3:0] clamp_len(input logic [3:0] len);
		if (len < SEQ_LEN_MIN)
			return SEQ_LEN_MIN;
		if (len > SEQ_LEN_MAX)
			return SEQ_LEN_MAX;
		return len;
	endfunction

	function automatic logic [3:0] next_pos(input logic [3:0] pos, input logic [3:0] len);
		if (pos >= 4'(len - 4'h1))
			return 4'h0;
		return 4'(pos + 4'h1);
	endfunction

endpackage

// ===== seq_step_if.sv
// Interface: one sequence position pointer and its controller
`timescale 1ns/10ps
interface seq_step_if;
	logic load;
	logic step;
	logic [3:0] start;
	logic [3:0] len;
	logic [3:0] pos;
	modport ctrl (output load, output step, output start, output len, input pos);
	modport ptr (input load, input step, input start, input len, output pos);
endinterface

// ===== block_queue_ram.sv
// Four 64-byte component block queues in one registered-read memory
`timescale 1ns/10ps
module block_queue_ram
	import seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] raddr,
	output logic [7:0] rdata
);
	typedef struct packed {
		logic [QUEUE_COUNT*BLOCK_CYCLES-1:0][7:0] mem;
		logic [7:0] rd;
	} ram_state_t;

	ram_state_t s_q;
	ram_state_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.rd = s_q.mem[raddr];
		if (we)
			s_d.mem[waddr] = wdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign rdata = s_q.rd;
endmodule

// ===== seq_pointer.sv
// Wrapping sequence position pointer
`timescale 1ns/10ps
module seq_pointer
	import seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	seq_step_if.ptr sp
);
	typedef struct packed {
		logic [3:0] pos;
	} ptr_state_t;

	ptr_state_t s_q;
	ptr_state_t s_d;
	logic [3:0] eff_len;

	always_comb
	begin
		s_d = s_q;
		eff_len = clamp_len(sp.len);
		if (sp.load)
			s_d.pos = sp.start;
		else if (sp.step)
			s_d.pos = next_pos(s_q.pos, eff_len);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign sp.pos = s_q.pos;

	a_pos_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && sp.step && !sp.load && s_q.pos >= 4'(eff_len - 4'h1)) |=> (s_q.pos == 4'h0))
		else $error("pointer did not wrap to bit zero");
	a_pos_range: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && sp.step && !sp.load) |=> (s_q.pos < $past(eff_len)))
		else $error("pointer left the programmed length");
endmodule

// ===== jpeg_block_table_sequencer.sv
// Top: block table sequencer with APB registers, block queues and bypass path
`timescale 1ns/10ps

// Summary of operation
// - Custom sequencing only in bypass; other modes use the fixed queue order. The code applies the programmed sequences in every mode.
// - Bypass feeds pixel data straight to the transform input.
// - Queue unit holds four separate 64-byte queues.
// - One component block enters the transform every 64 cycles.
// - Each block picks one of four quantizer tables from two sequences.
// - Luma/chroma register: 14 bits, length 13:10, sequence 9:0, write-only.
// - Length is 5 to 10; only bits 0 to length-1 are used.
// - Bit 0 luma, 1 chroma; consumed upward, wrapping to bit zero.
// - Start bit 2 for gray or decompression, else bit 5.
// - Bank register, 10 bits: 0 bank A, 1 bank B, same stepping.
// - Entropy register, 10 bits from bit zero: 0 luma set, 1 chroma.
// - Entropy and predictor bits used equal decoder length, at least 5.
// - Same-position predictor high and low bits form a two-bit index.
// - Entropy and predictor sequences run without padding entries.
module jpeg_block_table_sequencer
	import seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_start,
	input wire logic [7:0] pixel_data_bus,
	input wire logic pixel_valid,
	output logic pixel_ready,
	output logic [7:0] dct_data,
	output logic dct_valid,
	output logic dct_block_start,
	output logic [1:0] quant_table_sel,
	output logic entropy_chroma_sel,
	output logic [1:0] predictor_sel
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [9:0] ent_seq;
		logic [9:0] pred_high;
		logic [9:0] pred_low;
		logic [3:0] dec_len;
		logic [9:0] yc_seq;
		logic [3:0] yc_len;
		logic [9:0] ab_seq;
		pixel_mode_t mode;
		logic decomp;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] wq;
		logic [5:0] wcnt;
		logic [QUEUE_COUNT-1:0] full;
		logic [1:0] rq;
		logic [5:0] rcnt;
		logic active;
		logic rd_pend;
		logic rd_first;
		logic [5:0] bcnt;
		logic pix_ready;
		logic [7:0] dct_data;
		logic dct_valid;
		logic dct_start;
		logic [1:0] quant_sel;
		logic ent_sel;
		logic [1:0] pred_sel;
	} top_state_t;

	localparam top_state_t TOP_RST = '{
		ent_seq: SEQ_RST, pred_high: SEQ_RST, pred_low: SEQ_RST, dec_len: LEN_RST,
		yc_seq: SEQ_RST, yc_len: LEN_RST, ab_seq: SEQ_RST, mode: MODE_GRAY,
		default: '0
	};

	top_state_t s_q;
	top_state_t s_d;

	seq_step_if quant_if ();
	seq_step_if ent_if ();

	logic bypass;
	logic wr_en;
	logic wr_commit;
	logic blk_start;
	logic [3:0] q_start;
	logic [1:0] rq_next;
	logic [7:0] ram_rdata;
	logic [1:0] q_pick;
	logic [1:0] p_pick;
	logic [3:0] yc_len_in;

	// ----------------------------------------------------------------
	// Sub-blocks
	// ----------------------------------------------------------------
	block_queue_ram u_queues (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.we(wr_en),
		.waddr({s_q.wq, s_q.wcnt}),
		.wdata(pixel_data_bus),
		.raddr({s_q.rq, s_q.rcnt}),
		.rdata(ram_rdata)
	);

	seq_pointer u_quant_ptr (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.sp(quant_if.ptr)
	);

	seq_pointer u_ent_ptr (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.sp(ent_if.ptr)
	);

	// ----------------------------------------------------------------
	// Pointer control
	// ----------------------------------------------------------------
	assign bypass = (s_q.mode == MODE_GRAY);
	assign q_start = s_q.decomp ? START_DECOMP
		: (bypass ? START_GRAY_COMP : START_COLOR_COMP);

	// Quantizer and bank sequences share one pointer and one length
	assign quant_if.load = frame_start;
	assign quant_if.step = blk_start;
	assign quant_if.start = q_start;
	assign quant_if.len = s_q.yc_len;
	// Entropy side has its own pointer, so no padding slots are needed
	assign ent_if.load = frame_start;
	assign ent_if.step = blk_start;
	assign ent_if.start = START_ENTROPY;
	assign ent_if.len = s_q.dec_len;

	assign q_pick = {s_q.ab_seq[quant_if.pos], s_q.yc_seq[quant_if.pos]};
	assign p_pick = {s_q.pred_high[ent_if.pos], s_q.pred_low[ent_if.pos]};
	assign yc_len_in = pwdata[YC_LEN_MSB:YC_LEN_LSB];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	assign wr_commit = psel && penable && s_q.pready;
	assign wr_en = !bypass && pixel_valid && !s_q.full[s_q.wq];
	assign rq_next = 2'(s_q.rq + 2'h1);

	always_comb
	begin
		s_d = s_q;
		blk_start = 1'b0;

		// APB: one wait state, then the access completes
		if (psel && penable && !s_q.pready)
		begin
			s_d.pready = 1'b1;
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
			case (paddr)
				ENTROPY_SEQ_ADDR, PRED_HIGH_ADDR, PRED_LOW_ADDR, DEC_LEN_ADDR, YC_SEQ_ADDR, AB_SEQ_ADDR:
					s_d.prdata = '0;
				CTRL_ADDR:
				begin
					s_d.prdata[CTRL_MODE_MSB:0] = s_q.mode;
					s_d.prdata[CTRL_DECOMP_BIT] = s_q.decomp;
				end
				STATUS_ADDR:
				begin
					s_d.prdata[STAT_QPOS_LSB +: 4] = quant_if.pos;
					s_d.prdata[STAT_EPOS_LSB +: 4] = ent_if.pos;
					s_d.prdata[STAT_FULL_LSB +: QUEUE_COUNT] = s_q.full;
					s_d.prdata[STAT_BYPASS_BIT] = bypass;
				end
				default:
					s_d.pslverr = 1'b1;
			endcase
		end
		else if (s_q.pready)
		begin
			s_d.pready = 1'b0;
			s_d.pslverr = 1'b0;
			s_d.prdata = '0;
		end

		// Sequence registers are write-only and read back as zero
		if (wr_commit && pwrite)
		begin
			case (paddr)
				ENTROPY_SEQ_ADDR:
					s_d.ent_seq = pwdata[SEQ_MSB:0];
				PRED_HIGH_ADDR:
					s_d.pred_high = pwdata[SEQ_MSB:0];
				PRED_LOW_ADDR:
					s_d.pred_low = pwdata[SEQ_MSB:0];
				DEC_LEN_ADDR:
					s_d.dec_len = pwdata[LEN_MSB:0];
				YC_SEQ_ADDR:
				begin
					s_d.yc_seq = pwdata[SEQ_MSB:0];
					s_d.yc_len = yc_len_in;
				end
				AB_SEQ_ADDR:
					s_d.ab_seq = pwdata[SEQ_MSB:0];
				CTRL_ADDR:
				begin
					s_d.mode = pixel_mode_t'(pwdata[CTRL_MODE_MSB:0]);
					s_d.decomp = pwdata[CTRL_DECOMP_BIT];
				end
				default:
					s_d.decomp = s_q.decomp;
			endcase
		end

		// Queue reader: drain a full queue over 64 cycles, chain to the next
		s_d.rd_pend = s_q.active;
		s_d.rd_first = s_q.active && (s_q.rcnt == '0);
		if (s_q.active)
		begin
			s_d.rcnt = 6'(s_q.rcnt + 6'h01);
			if (s_q.rcnt == BLOCK_LAST)
			begin
				s_d.full[s_q.rq] = 1'b0;
				s_d.rq = rq_next;
			end
		end

		// Queue writer; a set lands after the clear so it is never lost
		if (wr_en)
		begin
			s_d.wcnt = 6'(s_q.wcnt + 6'h01);
			if (s_q.wcnt == BLOCK_LAST)
			begin
				s_d.full[s_q.wq] = 1'b1;
				s_d.wq = 2'(s_q.wq + 2'h1);
			end
		end

		if (s_q.active && s_q.rcnt == BLOCK_LAST)
			s_d.active = s_d.full[rq_next];
		else if (!s_q.active && !bypass)
			s_d.active = s_q.full[s_q.rq];

		// Transform input: straight pixels in bypass, queue data otherwise
		if (bypass)
		begin
			s_d.dct_data = pixel_data_bus;
			s_d.dct_valid = pixel_valid;
			blk_start = pixel_valid && (s_q.bcnt == '0);
			if (pixel_valid)
				s_d.bcnt = 6'(s_q.bcnt + 6'h01);
		end
		else
		begin
			s_d.dct_data = ram_rdata;
			s_d.dct_valid = s_q.rd_pend;
			blk_start = s_q.rd_first;
		end
		s_d.dct_start = blk_start;

		if (blk_start)
		begin
			s_d.quant_sel = q_pick;
			s_d.ent_sel = s_q.ent_seq[ent_if.pos];
			s_d.pred_sel = p_pick;
		end

		// A frame restarts queues and block counting
		if (frame_start)
		begin
			s_d.wq = '0;
			s_d.wcnt = '0;
			s_d.rq = '0;
			s_d.rcnt = '0;
			s_d.full = '0;
			s_d.active = 1'b0;
			s_d.bcnt = '0;
		end

		s_d.pix_ready = bypass || !s_d.full[s_d.wq];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= TOP_RST;
		else if (ce)
			s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign pixel_ready = s_q.pix_ready;
	assign dct_data = s_q.dct_data;
	assign dct_valid = s_q.dct_valid;
	assign dct_block_start = s_q.dct_start;
	assign quant_table_sel = s_q.quant_sel;
	assign entropy_chroma_sel = s_q.ent_sel;
	assign predictor_sel = s_q.pred_sel;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [6:0] gap_q;
	logic seen_q;

	// Counts enabled cycles since the last block start or frame start
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end
		else if (ce)
		begin
			if (blk_start || frame_start)
			begin
				gap_q <= '0;
				seen_q <= blk_start;
			end
			else if (gap_q != 7'h7f)
				gap_q <= 7'(gap_q + 7'h01);
		end
	end

	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_bypass_path: assert property ((ce && bypass && pixel_valid) |=>
		(dct_valid && dct_data == $past(pixel_data_bus)))
		else $error("bypass pixel did not reach the transform input");
	a_block_spacing: assert property ((ce && blk_start && seen_q && !frame_start) |->
		(gap_q >= 7'(BLOCK_LAST)))
		else $error("component blocks closer than 64 cycles");
	a_queue_fill: assert property ((ce && wr_en && s_q.wcnt == BLOCK_LAST && !frame_start) |=>
		(s_q.full[$past(s_q.wq)] && !pixel_ready == s_q.full[s_q.wq]))
		else $error("filled queue not marked full");
	a_quant_select: assert property ((ce && blk_start) |=>
		(dct_block_start && quant_table_sel == $past(q_pick)))
		else $error("quantizer table select mismatch");
	a_start_bit: assert property ((ce && frame_start) |=>
		(quant_if.pos == $past(q_start)))
		else $error("quantizer pointer not at its start bit");
	a_entropy_origin: assert property ((ce && frame_start) |=>
		(ent_if.pos == START_ENTROPY))
		else $error("entropy pointer not at bit zero");
	a_pred_select: assert property ((ce && blk_start) |=>
		(predictor_sel == $past(p_pick)))
		else $error("predictor index mismatch");
	a_len_write: assert property ((ce && wr_commit && pwrite && paddr == YC_SEQ_ADDR) |=>
		(ce || !ce) &&
		(s_q.yc_len == $past(yc_len_in)))
		else $error("length field not stored");

	c_bypass_block: cover property (ce && bypass && blk_start);
	c_queue_block: cover property (ce && !bypass && blk_start ##[1:200] (ce && blk_start));
	c_pointer_wrap: cover property (ce && blk_start && quant_if.pos == '0 && seen_q);
endmodule

// ===== apb_host_model.sv
// Host model: APB requester that programs the sequence registers
`timescale 1ns/10ps
module apb_host_model
(
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// One transfer; waits for pready as long as it takes, the bench watchdog ends a hang
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] data,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released bus shows no stale value
		paddr <= ~addr;
		pwdata <= ~data;
	endtask
endmodule

// ===== jpeg_block_table_sequencer_tb_top.sv
// Testbench: random bypass and queue-mode streams against a table selection model
`timescale 1ns/10ps
module jpeg_block_table_sequencer_tb_top;
	import seq_pkg::*;

	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, frame_start, pixel_valid, pixel_ready;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] pixel_data_bus, dct_data;
	logic dct_valid, dct_block_start, entropy_chroma_sel, err, exp_v, exp_bs, was_en, bypass, first_bs, run_chk;
	logic [1:0] quant_table_sel, predictor_sel;
	logic [9:0] yc, ab, ent, ph, pl;
	logic [7:0] fifo[$];
	int seed, i, m, ql, qlen, elen, qpos, epos, start, nacc, gap, mismatches, n_compared;

	jpeg_block_table_sequencer uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frame_start(frame_start), .pixel_data_bus(pixel_data_bus), .pixel_valid(pixel_valid),
		.pixel_ready(pixel_ready), .dct_data(dct_data), .dct_valid(dct_valid), .dct_block_start(dct_block_start),
		.quant_table_sel(quant_table_sel), .entropy_chroma_sel(entropy_chroma_sel), .predictor_sel(predictor_sel));

	apb_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	function automatic int step(input int p, input int len);
		return (p >= len - 1) ? 0 : p + 1;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic reg_wr(input logic [15:0] addr, input logic [31:0] data);
		host.xfer(1'b1, addr, data, rd, err);
		check({31'h0, err}, 32'h0);
	endtask

	task automatic prog(input logic [2:0] mode, input logic dec, input int len);
		yc = 10'($random(seed));
		ab = 10'($random(seed));
		ent = 10'($random(seed));
		ph = 10'($random(seed));
		pl = 10'($random(seed));
		qlen = len;
		elen = 5 + int'($unsigned($random(seed)) % 6);
		start = (mode == 3'h0 || dec) ? 2 : 5;
		bypass = (mode == 3'h0);
		// Outside bypass the host keeps the default sequences
		if (!bypass)
		begin
			yc = SEQ_RST;
			ab = SEQ_RST;
			ent = SEQ_RST;
			ph = SEQ_RST;
			pl = SEQ_RST;
			qlen = int'(LEN_RST);
			elen = int'(LEN_RST);
		end
		reg_wr(YC_SEQ_ADDR, {18'h0, 4'(qlen), yc});
		reg_wr(AB_SEQ_ADDR, {22'h0, ab});
		reg_wr(ENTROPY_SEQ_ADDR, {22'h0, ent});
		reg_wr(PRED_HIGH_ADDR, {22'h0, ph});
		reg_wr(PRED_LOW_ADDR, {22'h0, pl});
		reg_wr(DEC_LEN_ADDR, {28'h0, 4'(elen)});
		reg_wr(CTRL_ADDR, {28'h0, dec, mode});
		host.xfer(1'b0, STATUS_ADDR, 32'h0, rd, err);
		check({31'h0, rd[STAT_BYPASS_BIT]}, {31'h0, bypass});
	endtask

	task automatic frame();
		@(posedge pclk);
		frame_start <= 1'b1;
		@(posedge pclk);
		frame_start <= 1'b0;
	endtask

	// Bytes are counted only where ce and valid are both driven high
	task automatic feed(input int n, input logic rnd);
		int sent;
		logic c, v;
		sent = 0;
		while (sent < n)
		begin
			@(posedge pclk);
			c = rnd ? ($random(seed) % 4 != 0) : 1'b1;
			v = rnd ? $random(seed) % 2 != 0 : 1'b1;
			ce <= c;
			pixel_valid <= v;
			pixel_data_bus <= 8'($random(seed));
			if (c && v)
				sent++;
		end
		@(posedge pclk);
		ce <= 1'b1;
		pixel_valid <= 1'b0;
		for (int k = 0; k < 400 && fifo.size() > 0; k++)
			@(posedge pclk);
		check(fifo.size(), 32'h0);
		check({31'h0, pixel_ready}, 32'h1);
	endtask

	// ----------------------------------------------------------------
	// Output monitor and selection model
	// ----------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (run_chk && was_en)
		begin
			if (bypass)
			begin
				check({31'h0, dct_valid}, {31'h0, exp_v});
				check({31'h0, dct_block_start}, {31'h0, exp_bs});
			end
			if (dct_valid === 1'b1)
				check({24'h0, dct_data}, fifo.size() > 0 ? {24'h0, fifo.pop_front()} : 32'hffff_ffff);
			if (dct_block_start === 1'b1)
			begin
				if (!bypass && !first_bs)
					check(gap, 32'd64);
				first_bs = 1'b0;
				gap = 0;
				check({30'h0, quant_table_sel}, {30'h0, ab[qpos], yc[qpos]});
				check({31'h0, entropy_chroma_sel}, {31'h0, ent[epos]});
				check({30'h0, predictor_sel}, {30'h0, ph[epos], pl[epos]});
				qpos = step(qpos, qlen);
				epos = step(epos, elen);
			end
		end
		was_en = ce;
		if (ce)
		begin
			gap++;
			exp_v = pixel_valid;
			exp_bs = pixel_valid && nacc % 64 == 0;
			if (frame_start)
			begin
				nacc = 0;
				qpos = start;
				epos = 0;
				gap = 0;
				first_bs = 1'b1;
				fifo.delete();
			end
			else if (pixel_valid && pixel_ready)
			begin
				fifo.push_back(pixel_data_bus);
				nacc++;
			end
		end
	end

	initial
	begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 7;
		presetn = 1'b0;
		ce = 1'b1;
		frame_start = 1'b0;
		pixel_valid = 1'b0;
		pixel_data_bus = 8'h00;
		run_chk = 1'b0;
		was_en = 1'b0;
		bypass = 1'b1;
		mismatches = 0;
		n_compared = 0;
		repeat (2) @(posedge pclk);
		check({24'h0, dct_valid, dct_block_start, quant_table_sel, entropy_chroma_sel, predictor_sel, pready}, 32'h0);
		presetn <= 1'b1;
		run_chk <= 1'b1;
		reg_wr(YC_SEQ_ADDR, 32'h0000_2155);
		host.xfer(1'b0, YC_SEQ_ADDR, 32'h0, rd, err);
		check(rd, 32'h0);
		host.xfer(1'b0, 16'h0004, 32'h0, rd, err);
		check({31'h0, err}, 32'h1);
		$display("Test registers done");
		for (i = 0; i < 4; i++)
		begin
			ql = (i == 0) ? 5 : (i == 1) ? 10 : 5 + int'($unsigned($random(seed)) % 6);
			prog(3'h0, i[0], ql);
			frame();
			feed(64 * 12, 1'b1);
			frame();
			feed(64 * 3, 1'b1);
			$display("Test bypass %0d done", i);
		end
		// Queue modes run the default sequences; the length argument is overridden
		for (m = 1; m < 6; m++)
		begin
			prog(3'(m), m == 5, 6 + int'($unsigned($random(seed)) % 5));
			frame();
			host.xfer(1'b0, STATUS_ADDR, 32'h0, rd, err);
			check({28'h0, rd[STAT_QPOS_LSB +: 4]}, 32'(start));
			check({28'h0, rd[STAT_EPOS_LSB +: 4]}, 32'h0);
			feed(64 * 8, 1'b0);
			$display("Test queue mode %0d done", m);
		end
		finish_test();
	end
endmodule
